/* File: common/ddi_pkg.sv */
// shared constants, types and decoded-instruction carrier of the decimal instruction decoder
// assumes a single 100 MHz clock and a digit-pair wide core storage read port
package ddi_pkg;

  // clock and machine-cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MACHINE_CYCLE_NS = 20000;
  localparam int MACHINE_CYCLE_CLKS = MACHINE_CYCLE_NS / CLK_PERIOD_NS;
  localparam int FETCH_CYCLES = 8;
  localparam int INDIR_CYCLES = 4;

  // instruction layout
  localparam int INSTR_DIGITS = 12;
  localparam int ADDR_DIGITS = 5;
  localparam int INSTR_PAIRS = INSTR_DIGITS / 2;
  localparam int INDIR_PAIRS = 3;
  localparam int IMM_MAX_DIRECT = 5;
  localparam int IMM_MAX_INDIRECT = 6;

  // storage and reset values
  localparam int ADDR_W = 17;
  localparam int MEM_SIZE_DEF = 20000;
  localparam logic [16:0] PC_RESET = 17'h00000;

  typedef struct packed {
    logic flag;
    logic [3:0] val;
  } ddi_digit_t;

  typedef enum logic [1:0] {
    DDI_S_FETCH = 2'h0,
    DDI_S_IND_P = 2'h1,
    DDI_S_IND_Q = 2'h2,
    DDI_S_EXEC = 2'h3
  } ddi_state_t;

  typedef enum logic [2:0] {
    DDI_GRP_ARITH = 3'h0,
    DDI_GRP_COMPARE = 3'h1,
    DDI_GRP_BRANCH = 3'h2,
    DDI_GRP_TRANSMIT = 3'h3,
    DDI_GRP_IO = 3'h4,
    DDI_GRP_CONTROL = 3'h5
  } ddi_group_t;

  typedef enum logic [2:0] {
    DDI_P_NONE = 3'h0,
    DDI_P_DEST = 3'h1,
    DDI_P_TARGET = 3'h2,
    DDI_P_SOURCE = 3'h3,
    DDI_P_ALPHA = 3'h4
  } ddi_p_role_t;

  typedef enum logic [2:0] {
    DDI_Q_NONE = 3'h0,
    DDI_Q_SOURCE = 3'h1,
    DDI_Q_INDICATOR = 3'h2,
    DDI_Q_UNIT = 3'h3,
    DDI_Q_NUMERIC = 3'h4,
    DDI_Q_IMMEDIATE = 3'h5
  } ddi_q_role_t;

  typedef struct packed {
    logic known;
    ddi_group_t group;
    ddi_p_role_t p_role;
    ddi_q_role_t q_role;
    logic imm;
    logic p_ind_ok;
    logic q_ind_ok;
  } ddi_opinfo_t;

  typedef struct packed {
    logic [7:0] op;
    ddi_opinfo_t info;
    logic [16:0] p_addr;
    logic [16:0] q_addr;
    logic [3:0] mod8;
    logic [3:0] mod9;
    logic [3:0] mod11;
    ddi_digit_t [5:0] imm;
    logic [2:0] imm_len;
  } ddi_decoded_t;

endpackage : ddi_pkg

/* File: src/ddi_decoder.sv */
// instruction fetch, decode and indirect address resolution for a digit-serial decimal processor
// assumes core storage answers each digit-pair read with mem_ack_i within the same machine cycle
// and an execution unit that flags its last machine cycle on exec_last_i
`timescale 1ns/10ps
// Operation
// RULE_01 - fetch always spans exactly eight 20 us machine cycles
// RULE_02 - next fetch starts right after the last execute cycle, no idle cycles
// RULE_03 - execute length varies with operation, field lengths and signs
// RULE_04 - first address is destination, branch target, output source or alphameric field
// RULE_05 - second address is source, indicator, unit selector or numeric field
// RULE_06 - shared operation codes are told apart by digits eight, nine and eleven
// RULE_07 - immediate instructions take digits seven to eleven as data
// RULE_08 - immediate data runs from digit eleven leftward, stopping at first flag
// RULE_09 - an address with a flagged units digit is indirect
// RULE_10 - indirection reads exactly five digits, inner flags ignored
// RULE_11 - a flagged substitute address is followed again until direct
// RULE_12 - substitution changes only the internal instruction copy, never storage
// RULE_13 - each indirection level adds four 20 us memory cycles
// RULE_14 - indirect first address flag also ends immediate data, six digits at most
// RULE_15 - indirection allowed on data address fields as the operation permits
// RULE_16 - arithmetic operation codes are recognised
// RULE_17 - compare and branch operation codes are recognised
// RULE_18 - every operation falls in one of six functional groups
// RULE_19 - instruction is twelve digits: operation, first and second address
// RULE_20 - software keeps instructions at even addresses
// RULE_21 - all indirection finishes before execution starts
// RULE_22 - indirect branch target takes five digits at the resolved location
module ddi_decoder #(
  parameter int MEM_SIZE = ddi_pkg::MEM_SIZE_DEF,
  parameter int MCYCLE_CLKS = ddi_pkg::MACHINE_CYCLE_CLKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic mem_ack_i,
  input wire logic [9:0] mem_data_i,
  input wire logic exec_last_i,
  input wire logic branch_take_i,
  output logic mem_rd_o,
  output logic [16:0] mem_addr_o,
  output logic exec_start_o,
  output logic fetch_active_o,
  output logic [16:0] pc_o,
  output ddi_pkg::ddi_decoded_t decoded_o
);

  if (MEM_SIZE < 2 || MEM_SIZE > 99999 || (MEM_SIZE % 2) != 0) begin : g_bad_mem
    $error("ddi_decoder: MEM_SIZE must be even and within five decimal digits");
  end

  logic tick;
  ddi_pkg::ddi_opinfo_t info;
  ddi_pkg::ddi_state_t state, next_state;
  logic [2:0] mc, next_mc;
  logic [2:0] rd_slot, next_rd_slot;
  logic [16:0] next_pc, ind_addr, next_ind_addr, next_mem_addr;
  ddi_pkg::ddi_digit_t [11:0] instr, next_instr;
  ddi_pkg::ddi_digit_t [5:0] ibuf, next_ibuf;
  logic q_pend, next_q_pend, next_mem_rd, next_exec_start, next_fetch_active;
  ddi_pkg::ddi_decoded_t next_dec;

  // machine-cycle enable
  ddi_tick_gen #(.CLKS(MCYCLE_CLKS)) u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  // operation classification from the two operation digits
  ddi_opclass u_class ( // RULE_16 RULE_17
    .op_i({instr[0].val, instr[1].val}),
    .info_o(info)
  );

  // addition modulo the installed storage size
  function automatic logic [16:0] wrap_add(input logic [16:0] a, input logic [16:0] d);
    logic [17:0] s;
    s = {1'b0, a} + {1'b0, d};
    if (s >= 18'(MEM_SIZE)) s = s - 18'(MEM_SIZE);
    return s[16:0];
  endfunction : wrap_add

  // subtraction modulo the installed storage size
  function automatic logic [16:0] wrap_sub(input logic [16:0] a, input logic [16:0] d);
    logic [17:0] s;
    if (a >= d) s = {1'b0, a} - {1'b0, d};
    else s = {1'b0, a} + 18'(MEM_SIZE) - {1'b0, d};
    return s[16:0];
  endfunction : wrap_sub

  // five decimal digits, index 4 high order, to binary; flags are ignored
  function automatic logic [16:0] to_addr(input ddi_pkg::ddi_digit_t [4:0] d);
    logic [16:0] acc;
    acc = 17'h00000;
    for (int i = 4; i >= 0; i--) begin
      acc = 17'(acc * 17'h0000A) + {13'h0000, d[i].val}; // RULE_10
    end
    return acc;
  endfunction : to_addr

  // next-state logic of fetch, indirection and execute sequencing
  always_comb begin
    ddi_pkg::ddi_digit_t [4:0] fld;
    logic [16:0] na;
    logic [16:0] pa;
    logic [16:0] qa;
    logic p_ind;
    logic q_ind;
    logic stop;
    int off;
    fld = '0;
    na = 17'h00000;
    pa = 17'h00000;
    qa = 17'h00000;
    p_ind = 1'b0;
    q_ind = 1'b0;
    stop = 1'b0;
    off = 0;
    next_state = state;
    next_mc = mc;
    next_rd_slot = rd_slot;
    next_pc = pc_o;
    next_ind_addr = ind_addr;
    next_instr = instr;
    next_ibuf = ibuf;
    next_q_pend = q_pend;
    next_dec = decoded_o;
    next_mem_addr = mem_addr_o;
    next_mem_rd = 1'b0;
    next_exec_start = 1'b0;
    // capture returned digit pairs; only the internal copy is ever written
    if (mem_ack_i) begin
      if (state == ddi_pkg::DDI_S_FETCH) begin
        next_instr[{rd_slot, 1'b0}] = mem_data_i[9:5]; // RULE_19
        next_instr[{rd_slot, 1'b1}] = mem_data_i[4:0];
      end else begin
        next_ibuf[{rd_slot, 1'b0}] = mem_data_i[9:5]; // RULE_10
        next_ibuf[{rd_slot, 1'b1}] = mem_data_i[4:0];
      end
    end
    if (tick) begin
      case (state)
        ddi_pkg::DDI_S_FETCH: begin
          next_mc = mc + 3'h1;
          if (mc < 3'(ddi_pkg::INSTR_PAIRS)) begin
            next_mem_rd = 1'b1;
            next_mem_addr = wrap_add(pc_o, {13'h0000, mc, 1'b0}); // RULE_20
            next_rd_slot = mc;
          end else if (mc == 3'(ddi_pkg::FETCH_CYCLES - 1)) begin // RULE_01
            pa = to_addr({instr[2], instr[3], instr[4], instr[5], instr[6]});
            qa = to_addr({instr[7], instr[8], instr[9], instr[10], instr[11]});
            p_ind = instr[6].flag & info.p_ind_ok; // RULE_09 RULE_15
            q_ind = instr[11].flag & info.q_ind_ok & ~info.imm; // RULE_09 RULE_15
            next_dec.op = {instr[0].val, instr[1].val};
            next_dec.info = info; // RULE_18
            next_dec.p_addr = pa; // RULE_04
            next_dec.q_addr = qa; // RULE_05
            next_dec.mod8 = instr[8].val; // RULE_06
            next_dec.mod9 = instr[9].val;
            next_dec.mod11 = instr[11].val;
            next_dec.imm = '0;
            next_dec.imm_len = 3'h0;
            if (info.imm) begin
              // scan from the units digit toward higher order
              for (int i = 0; i < ddi_pkg::IMM_MAX_DIRECT; i++) begin
                if (!stop) begin
                  next_dec.imm[i] = instr[11 - i]; // RULE_07 RULE_08
                  next_dec.imm_len = 3'(i + 1);
                  stop = instr[11 - i].flag;
                end
              end
              if (!stop && p_ind) begin
                next_dec.imm[ddi_pkg::IMM_MAX_INDIRECT - 1] = instr[6]; // RULE_14
                next_dec.imm_len = 3'(ddi_pkg::IMM_MAX_INDIRECT);
              end
            end
            next_q_pend = q_ind;
            next_mc = 3'h0;
            if (p_ind) begin
              next_state = ddi_pkg::DDI_S_IND_P;
              next_ind_addr = pa;
            end else if (q_ind) begin
              next_state = ddi_pkg::DDI_S_IND_Q;
              next_ind_addr = qa;
            end else begin
              next_state = ddi_pkg::DDI_S_EXEC;
              next_exec_start = 1'b1;
            end
          end
        end
        ddi_pkg::DDI_S_IND_P, ddi_pkg::DDI_S_IND_Q: begin
          next_mc = mc + 3'h1;
          if (mc < 3'(ddi_pkg::INDIR_PAIRS)) begin
            // three pairs cover the five digits ending at the pointed units digit
            next_mem_rd = 1'b1;
            next_mem_addr = wrap_add(wrap_sub({ind_addr[16:1], 1'b0}, 17'h00004), {13'h0000, mc, 1'b0});
            next_rd_slot = mc;
          end else begin
            off = ind_addr[0] ? 1 : 0;
            for (int j = 0; j < ddi_pkg::ADDR_DIGITS; j++) begin
              fld[4 - j] = ibuf[off + j]; // RULE_10
            end
            na = to_addr(fld);
            next_mc = 3'h0;
            if (fld[0].flag) begin
              next_ind_addr = na; // RULE_11 RULE_13
            end else if (state == ddi_pkg::DDI_S_IND_P) begin
              next_dec.p_addr = na; // RULE_12 RULE_22
              if (q_pend) begin
                next_state = ddi_pkg::DDI_S_IND_Q;
                next_ind_addr = decoded_o.q_addr;
              end else begin
                next_state = ddi_pkg::DDI_S_EXEC; // RULE_21
                next_exec_start = 1'b1;
              end
            end else begin
              next_dec.q_addr = na; // RULE_12
              next_q_pend = 1'b0;
              next_state = ddi_pkg::DDI_S_EXEC; // RULE_21
              next_exec_start = 1'b1;
            end
          end
        end
        ddi_pkg::DDI_S_EXEC: begin
          if (exec_last_i) begin // RULE_03
            next_state = ddi_pkg::DDI_S_FETCH; // RULE_02
            next_mc = 3'h0;
            if (branch_take_i && decoded_o.info.group == ddi_pkg::DDI_GRP_BRANCH) begin
              next_pc = decoded_o.p_addr; // RULE_22
            end else begin
              next_pc = wrap_add(pc_o, 17'(ddi_pkg::INSTR_DIGITS)); // RULE_19
            end
          end
        end
        default: begin
          next_state = ddi_pkg::DDI_S_FETCH;
          next_mc = 3'h0;
        end
      endcase
    end
    next_fetch_active = (next_state == ddi_pkg::DDI_S_FETCH);
  end

  // state registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state <= ddi_pkg::DDI_S_FETCH;
      mc <= 3'h0;
      rd_slot <= 3'h0;
      pc_o <= ddi_pkg::PC_RESET;
      ind_addr <= 17'h00000;
      instr <= '0;
      ibuf <= '0;
      q_pend <= 1'b0;
      decoded_o <= '0;
      mem_addr_o <= 17'h00000;
      mem_rd_o <= 1'b0;
      exec_start_o <= 1'b0;
      fetch_active_o <= 1'b1;
    end else begin
      state <= next_state;
      mc <= next_mc;
      rd_slot <= next_rd_slot;
      pc_o <= next_pc;
      ind_addr <= next_ind_addr;
      instr <= next_instr;
      ibuf <= next_ibuf;
      q_pend <= next_q_pend;
      decoded_o <= next_dec;
      mem_addr_o <= next_mem_addr;
      mem_rd_o <= next_mem_rd;
      exec_start_o <= next_exec_start;
      fetch_active_o <= next_fetch_active;
    end
  end

  // checks on sequencing, storage reads and decoded fields
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_FETCH_STAYS: assert property (state == ddi_pkg::DDI_S_FETCH && tick && mc < 3'h7 |=> // RULE_01
      state == ddi_pkg::DDI_S_FETCH) else $error("fetch left before eight machine cycles");
  AST_FETCH_ENDS: assert property (state == ddi_pkg::DDI_S_FETCH && tick && mc == 3'h7 |=> // RULE_01
      state != ddi_pkg::DDI_S_FETCH) else $error("fetch ran past eight machine cycles");
  AST_NO_IDLE: assert property (state == ddi_pkg::DDI_S_EXEC && tick && exec_last_i |=> // RULE_02
      state == ddi_pkg::DDI_S_FETCH && mc == 3'h0) else $error("idle gap before next fetch");
  AST_IND_FOUR: assert property ((state == ddi_pkg::DDI_S_IND_P || state == ddi_pkg::DDI_S_IND_Q) // RULE_13
      && tick && mc < 3'h3 |=> $stable(state)) else $error("indirection shorter than four cycles");
  AST_EXEC_DIRECT: assert property (exec_start_o |-> state == ddi_pkg::DDI_S_EXEC && !q_pend) // RULE_21
      else $error("execution began with indirection pending");
  AST_IMM_LEN: assert property (exec_start_o && decoded_o.info.imm |-> decoded_o.imm_len >= 3'h1 && // RULE_14
      decoded_o.imm_len <= 3'h6) else $error("immediate length out of range");
  AST_EVEN_FETCH: assert property (mem_rd_o |-> !mem_addr_o[0] ##1 !mem_rd_o) // RULE_20
      else $error("odd or repeated storage read");
  AST_BRANCH_TARGET: assert property (state == ddi_pkg::DDI_S_EXEC && tick && exec_last_i && branch_take_i // RULE_22
      && decoded_o.info.group == ddi_pkg::DDI_GRP_BRANCH |=> pc_o == $past(decoded_o.p_addr))
      else $error("branch did not load resolved target");
  AST_GROUP_VALID: assert property (exec_start_o |-> decoded_o.info.group <= ddi_pkg::DDI_GRP_CONTROL && // RULE_18
      (!decoded_o.info.imm || (decoded_o.info.q_role == ddi_pkg::DDI_Q_IMMEDIATE &&
      decoded_o.info.group != ddi_pkg::DDI_GRP_IO && decoded_o.info.group != ddi_pkg::DDI_GRP_CONTROL)))
      else $error("operation outside its functional group");

endmodule : ddi_decoder

/* File: src/ddi_opclass.sv */
// operation-code classifier: group, field roles, immediate and indirect permissions
// assumes the two operation digits arrive as packed decimal, high digit first
`timescale 1ns/10ps
module ddi_opclass (
  input wire logic [7:0] op_i,
  output ddi_pkg::ddi_opinfo_t info_o
);

  // table of every known operation code
  always_comb begin
    info_o = '{known: 1'b0, group: ddi_pkg::DDI_GRP_CONTROL, p_role: ddi_pkg::DDI_P_NONE,
               q_role: ddi_pkg::DDI_Q_NONE, imm: 1'b0, p_ind_ok: 1'b0, q_ind_ok: 1'b0};
    case (op_i)
      8'h21, 8'h22, 8'h23, 8'h28, 8'h29, 8'h01, 8'h02, 8'h03, 8'h09: begin // RULE_16
        info_o = '{1'b1, ddi_pkg::DDI_GRP_ARITH, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_SOURCE, 1'b0, 1'b1, 1'b1};
      end
      8'h11, 8'h12, 8'h13, 8'h18, 8'h19: begin // RULE_16
        info_o = '{1'b1, ddi_pkg::DDI_GRP_ARITH, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_IMMEDIATE, 1'b1, 1'b1, 1'b0};
      end
      8'h24: begin // RULE_17
        info_o = '{1'b1, ddi_pkg::DDI_GRP_COMPARE, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_SOURCE, 1'b0, 1'b1, 1'b1};
      end
      8'h14: begin // RULE_17
        info_o = '{1'b1, ddi_pkg::DDI_GRP_COMPARE, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_IMMEDIATE, 1'b1, 1'b1, 1'b0};
      end
      8'h49: begin // RULE_17
        info_o = '{1'b1, ddi_pkg::DDI_GRP_BRANCH, ddi_pkg::DDI_P_TARGET, ddi_pkg::DDI_Q_NONE, 1'b0, 1'b1, 1'b0};
      end
      8'h44, 8'h45, 8'h55, 8'h43, 8'h27, 8'h07: begin // RULE_17
        info_o = '{1'b1, ddi_pkg::DDI_GRP_BRANCH, ddi_pkg::DDI_P_TARGET, ddi_pkg::DDI_Q_SOURCE, 1'b0, 1'b1, 1'b1};
      end
      8'h46, 8'h47: begin // RULE_17 RULE_05
        info_o = '{1'b1, ddi_pkg::DDI_GRP_BRANCH, ddi_pkg::DDI_P_TARGET, ddi_pkg::DDI_Q_INDICATOR, 1'b0, 1'b1, 1'b0};
      end
      8'h17: begin // RULE_17
        info_o = '{1'b1, ddi_pkg::DDI_GRP_BRANCH, ddi_pkg::DDI_P_TARGET, ddi_pkg::DDI_Q_IMMEDIATE, 1'b1, 1'b1, 1'b0};
      end
      8'h42: begin // RULE_17
        info_o = '{1'b1, ddi_pkg::DDI_GRP_BRANCH, ddi_pkg::DDI_P_NONE, ddi_pkg::DDI_Q_NONE, 1'b0, 1'b0, 1'b0};
      end
      8'h25, 8'h26, 8'h31, 8'h08, 8'h05, 8'h06: begin
        info_o = '{1'b1, ddi_pkg::DDI_GRP_TRANSMIT, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_SOURCE, 1'b0, 1'b1, 1'b1};
      end
      8'h15, 8'h16: begin
        info_o = '{1'b1, ddi_pkg::DDI_GRP_TRANSMIT, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_IMMEDIATE, 1'b1, 1'b1, 1'b0};
      end
      8'h72, 8'h73: begin // RULE_04 RULE_05
        info_o = '{1'b1, ddi_pkg::DDI_GRP_TRANSMIT, ddi_pkg::DDI_P_ALPHA, ddi_pkg::DDI_Q_NUMERIC, 1'b0, 1'b1, 1'b1};
      end
      8'h36, 8'h37, 8'h34: begin // RULE_05
        info_o = '{1'b1, ddi_pkg::DDI_GRP_IO, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_UNIT, 1'b0, 1'b1, 1'b0};
      end
      8'h38, 8'h35, 8'h39: begin // RULE_04
        info_o = '{1'b1, ddi_pkg::DDI_GRP_IO, ddi_pkg::DDI_P_SOURCE, ddi_pkg::DDI_Q_UNIT, 1'b0, 1'b1, 1'b0};
      end
      8'h32, 8'h33: begin
        info_o = '{1'b1, ddi_pkg::DDI_GRP_CONTROL, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_NONE, 1'b0, 1'b1, 1'b0};
      end
      8'h71: begin
        info_o = '{1'b1, ddi_pkg::DDI_GRP_CONTROL, ddi_pkg::DDI_P_DEST, ddi_pkg::DDI_Q_SOURCE, 1'b0, 1'b1, 1'b1};
      end
      8'h48, 8'h41: begin
        info_o = '{1'b1, ddi_pkg::DDI_GRP_CONTROL, ddi_pkg::DDI_P_NONE, ddi_pkg::DDI_Q_NONE, 1'b0, 1'b0, 1'b0};
      end
      default: begin
        info_o.known = 1'b0;
      end
    endcase
  end

endmodule : ddi_opclass

/* File: src/ddi_tick_gen.sv */
// machine-cycle enable divider: one-cycle pulse every CLKS reference clocks
// assumes the synchronous active-low reset of the decoder
`timescale 1ns/10ps
module ddi_tick_gen #(
  parameter int CLKS = ddi_pkg::MACHINE_CYCLE_CLKS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);

  if (CLKS < 2 || CLKS > 65535) begin : g_bad
    $error("ddi_tick_gen: CLKS out of range");
  end

  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_tick;

  // count down and pulse on the last clock of each machine cycle
  always_comb begin
    next_tick = 1'b0;
    if (cnt == 16'h0000) begin
      next_cnt = 16'(CLKS - 1);
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt <= 16'(CLKS - 1);
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule : ddi_tick_gen

/* File: testbench/ddi_core_model.sv */
// core storage model answering digit-pair reads after a chosen lag
// assumes one read pulse at a time from the decoder, single clock
`timescale 1ns/10ps
module ddi_core_model #(
  parameter int MEM_SIZE = 200
) (
  input wire logic ref_clk_i,
  input wire logic mem_rd_i,
  input wire logic [16:0] mem_addr_i,
  input wire logic [1:0] lag_i,
  output logic mem_ack_o,
  output logic [9:0] mem_data_o
);
  ddi_pkg::ddi_digit_t mem [MEM_SIZE];
  logic [16:0] addr;
  logic [1:0] lag;
  logic busy;
  // storage cleared, bus idle
  initial begin
    foreach (mem[i]) mem[i] = 5'h00;
    busy = 1'b0;
    mem_ack_o = 1'b0;
    mem_data_o = 10'h155;
  end
  // one read in flight; after the answer the bus shows the inverse of the last pair
  always @(posedge ref_clk_i) begin
    mem_ack_o <= 1'b0;
    if (mem_ack_o) begin
      mem_data_o <= ~mem_data_o;
    end
    if (mem_rd_i) begin
      addr <= mem_addr_i;
      lag <= lag_i;
      busy <= 1'b1;
    end else if (busy && lag != 2'h0) begin
      lag <= lag - 2'h1;
    end else if (busy) begin
      mem_ack_o <= 1'b1;
      mem_data_o <= {mem[addr], mem[addr + 17'h1]};
      busy <= 1'b0;
    end
  end
endmodule : ddi_core_model

/* File: testbench/test_decimal_instr_decode_indirect.sv */
// self-checking bench of the decimal instruction decoder beside a core storage model
// assumes shortened machine cycles and a storage of two hundred digits
`timescale 1ns/10ps
module test_decimal_instr_decode_indirect;
  localparam int MC = 8;
  localparam int MEM = 200;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic exec_last_i = 1'b0;
  logic branch_take_i = 1'b0;
  logic [1:0] lag = 2'h0;
  logic mem_ack;
  logic [9:0] mem_data;
  logic mem_rd;
  logic [16:0] mem_addr;
  logic exec_start;
  logic fetch_active;
  logic [16:0] pc_o;
  ddi_pkg::ddi_decoded_t dec;
  int error_cnt = 0;
  int checked = 0;
  int pc = 0;

  // 10 ns clock
  always #5 ref_clk_i = ~ref_clk_i;

  // decoder and storage
  ddi_decoder #(.MEM_SIZE(MEM), .MCYCLE_CLKS(MC)) i_dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .mem_ack_i(mem_ack),
    .mem_data_i(mem_data),
    .exec_last_i(exec_last_i),
    .branch_take_i(branch_take_i),
    .mem_rd_o(mem_rd),
    .mem_addr_o(mem_addr),
    .exec_start_o(exec_start),
    .fetch_active_o(fetch_active),
    .pc_o(pc_o),
    .decoded_o(dec)
  );
  ddi_core_model #(.MEM_SIZE(MEM)) i_mem (
    .ref_clk_i(ref_clk_i),
    .mem_rd_i(mem_rd),
    .mem_addr_i(mem_addr),
    .lag_i(lag),
    .mem_ack_o(mem_ack),
    .mem_data_o(mem_data)
  );

  task automatic results;
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic check(input bit ok, input string what);
    checked++;
    if (!ok) begin
      error_cnt++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check

  // five digits from a upward, fl[0] on the rightmost
  task automatic put5(input int a, input int v, input logic [4:0] fl);
    for (int i = 0; i < 5; i++) begin
      i_mem.mem[(a + i) % MEM] = {fl[4 - i], 4'((v / (10 ** (4 - i))) % 10)};
    end
  endtask : put5

  // instruction placed at the expected even address
  task automatic put_instr(input logic [7:0] op, input int p, input int q, input logic [4:0] pf, input logic [4:0] qf);
    i_mem.mem[pc] = {1'b0, op[7:4]};
    i_mem.mem[pc + 1] = {1'b0, op[3:0]};
    put5(pc + 2, p, pf);
    put5(pc + 7, q, qf);
  endtask : put_instr

  // wait for decode, stretch execute by hold machine cycles, then end it
  task automatic run_instr(input int fetch_mc, input logic take, input int target, input int hold);
    int n;
    n = 0;
    while (exec_start !== 1'b1 && n < 400) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check(exec_start === 1'b1 && (fetch_mc == 0 || n == fetch_mc * MC), "decode latency");
    check(pc_o === 17'(pc) && fetch_active === 1'b0, "execute entry");
    repeat (hold * MC) begin
      @(posedge ref_clk_i);
      #1;
    end
    check(fetch_active === 1'b0, "execute cut short");
    exec_last_i = 1'b1;
    branch_take_i = take;
    n = 0;
    while (fetch_active !== 1'b1 && n < MC + 2) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    check(fetch_active === 1'b1, "no fetch after execute");
    exec_last_i = 1'b0;
    branch_take_i = 1'b0;
    pc = take ? target : (pc + 12) % MEM;
  endtask : run_instr

  // plain add, both fields direct
  task automatic t_direct;
    put_instr(8'h21, 50, 60, 5'h00, 5'h00);
    run_instr(0, 1'b0, 0, 0);
    check(dec.p_addr === 17'h32 && dec.q_addr === 17'h3C && dec.imm_len === 3'h0, "direct fields");
    check(dec.info.p_role === ddi_pkg::DDI_P_DEST && dec.info.q_role === ddi_pkg::DDI_Q_SOURCE, "roles");
    check(dec.info.p_ind_ok === 1'b1 && dec.info.q_ind_ok === 1'b1, "indirect permission");
  endtask : t_direct

  // P chained twice, Q once with flags inside its field
  task automatic t_indirect;
    put_instr(8'h21, 70, 80, 5'h01, 5'h01);
    put5(66, 90, 5'h01);
    put5(86, 120, 5'h00);
    put5(76, 140, 5'h1E);
    run_instr(20, 1'b0, 0, 0);
    check(dec.p_addr === 17'h78 && dec.q_addr === 17'h8C, "indirect fields");
    check(i_mem.mem[18] === 5'h10, "stored instruction");
  endtask : t_indirect

  // literal stops at the flagged third digit
  task automatic t_imm;
    put_instr(8'h16, 150, 18765, 5'h00, 5'h04);
    run_instr(8, 1'b0, 0, 0);
    check(dec.imm_len === 3'h3 && dec.imm[2:0] === {5'h17, 5'h06, 5'h05}, "literal");
    check(dec.info.imm === 1'b1 && dec.info.q_role === ddi_pkg::DDI_Q_IMMEDIATE, "literal role");
    check(dec.info.p_ind_ok === 1'b1 && dec.info.q_ind_ok === 1'b0, "literal permission");
  endtask : t_imm

  // literal closed by the flagged units digit of an indirect P
  task automatic t_imm_ind;
    put_instr(8'h11, 160, 650, 5'h01, 5'h00);
    put5(156, 170, 5'h00);
    run_instr(12, 1'b0, 0, 0);
    check(dec.imm_len === 3'h6 && dec.imm === {5'h10, 5'h00, 5'h00, 5'h06, 5'h05, 5'h00}, "six digits");
    check(dec.p_addr === 17'hAA, "literal P");
  endtask : t_imm_ind

  // taken branch through an indirect target, slow storage, long execute
  task automatic t_branch;
    lag = 2'h3;
    put_instr(8'h49, 188, 0, 5'h01, 5'h00);
    put5(184, 60, 5'h00);
    run_instr(12, 1'b1, 60, 3);
    check(dec.p_addr === 17'h3C && dec.info.p_role === ddi_pkg::DDI_P_TARGET, "branch target");
    lag = 2'h0;
  endtask : t_branch

  // each code once, grouped in list order, modifier digits 1, 2, 9
  task automatic t_codes;
    logic [7:0] ops [$] = '{8'h21, 8'h11, 8'h22, 8'h12, 8'h23, 8'h13, 8'h28, 8'h18, 8'h29, 8'h19, 8'h01, 8'h02,
      8'h03, 8'h09, 8'h24, 8'h14, 8'h49, 8'h44, 8'h45, 8'h55, 8'h43, 8'h46, 8'h47, 8'h27, 8'h17, 8'h42,
      8'h07, 8'h26, 8'h72, 8'h73, 8'h25, 8'h15, 8'h31, 8'h08, 8'h05, 8'h06, 8'h16, 8'h38, 8'h36, 8'h37,
      8'h34, 8'h35, 8'h39, 8'h48, 8'h32, 8'h33, 8'h71, 8'h41, 8'h99};
    ddi_pkg::ddi_group_t g;
    foreach (ops[i]) begin
      g = i < 14 ? ddi_pkg::DDI_GRP_ARITH : i < 16 ? ddi_pkg::DDI_GRP_COMPARE : i < 27 ? ddi_pkg::DDI_GRP_BRANCH :
        i < 37 ? ddi_pkg::DDI_GRP_TRANSMIT : i < 43 ? ddi_pkg::DDI_GRP_IO : ddi_pkg::DDI_GRP_CONTROL;
      put_instr(ops[i], 0, 1209, 5'h00, 5'h00);
      run_instr(8, 1'b0, 0, 0);
      check(dec.op === ops[i] && dec.info.group === g, "group");
      check(dec.info.known === 1'(ops[i] != 8'h99), "known code");
      check({dec.mod8, dec.mod9, dec.mod11} === 12'h129, "modifiers");
      check(!(ops[i] inside {8'h72, 8'h73}) || dec.info.q_role === ddi_pkg::DDI_Q_NUMERIC, "strip role");
      check(!(ops[i] inside {8'h72, 8'h73}) || dec.info.p_role === ddi_pkg::DDI_P_ALPHA, "strip P role");
      check(!(ops[i] inside {8'h38, 8'h35, 8'h39}) || dec.info.p_role === ddi_pkg::DDI_P_SOURCE, "out role");
      check(g != ddi_pkg::DDI_GRP_IO || dec.info.q_role === ddi_pkg::DDI_Q_UNIT, "unit role");
      check(!(ops[i] inside {8'h46, 8'h47}) || dec.info.q_role === ddi_pkg::DDI_Q_INDICATOR, "ind role");
    end
  endtask : t_codes

  // reset, then scenarios in program order
  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    t_direct();
    t_indirect();
    t_imm();
    t_imm_ind();
    t_branch();
    t_codes();
    results();
  end

  // watchdog far beyond the expected run
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    error_cnt++;
    results();
  end
endmodule : test_decimal_instr_decode_indirect
